// file: rtl/bps_pattern_source.sv
// Pattern generator data source with trigger output and register slave
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "bps_defines.svh"
module bps_pattern_source #(
	parameter int FRAME_BYTES = `BPS_FRAME_BYTES,
	parameter int LONG_BLOCKS = `BPS_LONG_BLOCKS
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [`BPS_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_long_option,
	input wire logic i_frame_option,
	output logic [25:0] o_long_addr,
	input wire logic i_long_bit,
	input wire logic i_rx_bit_en,
	input wire logic i_rx_sync,
	input wire logic i_rx_err,
	output logic o_data,
	output logic o_data_n,
	output logic o_trig
);
	// ****************************************
	// Option pins and bus handshake
	// ****************************************
	logic [1:0] lopt_sync_ff;
	logic [1:0] fopt_sync_ff;
	logic ack_ff;
	logic req;
	logic wr_en;
	logic [31:0] rdata_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lopt_sync_ff <= 2'h0;
			fopt_sync_ff <= 2'h0;
		end else begin
			lopt_sync_ff <= {lopt_sync_ff[0], i_long_option};
			fopt_sync_ff <= {fopt_sync_ff[0], i_frame_option};
		end
	end

	// One wait state per access gives the read mux a full cycle
	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack_ff;
	assign wr_en = i_avs_write & ack_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ack_ff <= 1'b0;
		else
			ack_ff <= req & ~ack_ff;
	end

	// ****************************************
	// Control registers
	// ****************************************
	bps_pkg::bps_pat_t type_ff;
	bps_pkg::bps_prbs_t prbs_len_ff;
	logic [2:0] pay_ff;
	logic neg_ff;
	bps_pkg::bps_trig_t trig_sel_ff;
	logic [8:0] slen_ff;
	logic [19:0] lblk_ff;
	logic [255:0] smem_ff;
	logic err_pend_ff;
	logic restart_ff;
	logic err_take;
	bps_pkg::bps_pat_t wr_type;
	logic [8:0] wr_slen;
	logic [19:0] wr_lblk;

	// An absent option cannot be chosen
	function automatic logic type_ok(input bps_pkg::bps_pat_t t, input logic lo, input logic fo);
		type_ok = !((t == bps_pkg::PAT_LONG && !lo) || (t == bps_pkg::PAT_FRAME && !fo));
	endfunction

	assign wr_type = bps_pkg::bps_pat_t'(i_avs_writedata[`BPS_CTRL_TYPE_LSB +: 2]);
	assign wr_slen = (i_avs_writedata[31:9] != 23'h0) ? `BPS_SLEN_MAX :
		(i_avs_writedata[8:0] < `BPS_SLEN_MIN) ? `BPS_SLEN_MIN :
		(i_avs_writedata[8:0] > `BPS_SLEN_MAX) ? `BPS_SLEN_MAX : i_avs_writedata[8:0];
	assign wr_lblk = (i_avs_writedata[31:27] != 5'h0 ||
		32'(i_avs_writedata[26:`BPS_LBLK_SHIFT]) > LONG_BLOCKS) ? 20'(LONG_BLOCKS) :
		(i_avs_writedata[26:`BPS_LBLK_SHIFT] < `BPS_LBLK_MIN) ? `BPS_LBLK_MIN :
		i_avs_writedata[26:`BPS_LBLK_SHIFT];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			type_ff <= bps_pkg::PAT_PRBS;
			prbs_len_ff <= bps_pkg::PRBS_7;
			pay_ff <= 3'h0;
			neg_ff <= 1'b0;
		end else if (wr_en && i_avs_address == `BPS_REG_CTRL) begin
			// A refused type must not shield a current type whose option has just dropped
			if (type_ok(wr_type, lopt_sync_ff[1], fopt_sync_ff[1]))
				type_ff <= wr_type;
			else if (!type_ok(type_ff, lopt_sync_ff[1], fopt_sync_ff[1]))
				type_ff <= bps_pkg::PAT_PRBS;
			if (i_avs_writedata[`BPS_CTRL_PRBS_LSB +: 3] < `BPS_PRBS_CODES)
				prbs_len_ff <= bps_pkg::bps_prbs_t'(i_avs_writedata[`BPS_CTRL_PRBS_LSB +: 3]);
			if (i_avs_writedata[`BPS_CTRL_PAY_LSB +: 3] < `BPS_PAY_CODES)
				pay_ff <= i_avs_writedata[`BPS_CTRL_PAY_LSB +: 3];
			neg_ff <= i_avs_writedata[`BPS_CTRL_NEG_BIT];
		end else if (!type_ok(type_ff, lopt_sync_ff[1], fopt_sync_ff[1])) begin
			type_ff <= bps_pkg::PAT_PRBS;
		end
	end

	// Single shared trigger choice serves both generator and checker
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			trig_sel_ff <= bps_pkg::TRG_TX16;
		else if (wr_en && i_avs_address == `BPS_REG_TRIG)
			trig_sel_ff <= bps_pkg::bps_trig_t'(i_avs_writedata[2:0]);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slen_ff <= `BPS_SLEN_MIN;
			lblk_ff <= `BPS_LBLK_MIN;
		end else if (wr_en && i_avs_address == `BPS_REG_SLEN) begin
			slen_ff <= wr_slen;
		end else if (wr_en && i_avs_address == `BPS_REG_LLEN) begin
			lblk_ff <= wr_lblk;
		end
	end

	// Index 0 is sent first; a byte is sent most significant bit first
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			smem_ff <= 256'h0;
		end else if (wr_en && i_avs_address == `BPS_REG_SBYTE) begin
			for (int j = 0; j < 8; j++)
				smem_ff[{i_avs_writedata[12:8], 3'(j)}] <= i_avs_writedata[7 - j];
		end else if (wr_en && i_avs_address == `BPS_REG_SBIT) begin
			smem_ff[i_avs_writedata[15:8]] <= i_avs_writedata[0];
		end
	end

	// A write that requests an error wins over the bit that consumes one
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			err_pend_ff <= 1'b0;
		else if (wr_en && i_avs_address == `BPS_REG_CTRL && i_avs_writedata[`BPS_CTRL_ERR_BIT])
			err_pend_ff <= 1'b1;
		else if (err_take)
			err_pend_ff <= 1'b0;
	end

	// Any control or length write restarts the pattern counters and sync; the random register runs on unless its length changes
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			restart_ff <= 1'b1;
		else
			restart_ff <= wr_en && (i_avs_address == `BPS_REG_CTRL ||
				i_avs_address == `BPS_REG_SLEN || i_avs_address == `BPS_REG_LLEN);
	end

	// ****************************************
	// Read-back
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= 32'h0;
		end else if (i_avs_read && !ack_ff) begin
			if (i_avs_address == `BPS_REG_CTRL)
				rdata_ff <= {23'h0, neg_ff, pay_ff, prbs_len_ff, type_ff};
			else if (i_avs_address == `BPS_REG_TRIG)
				rdata_ff <= {29'h0, trig_sel_ff};
			else if (i_avs_address == `BPS_REG_SLEN)
				rdata_ff <= {23'h0, slen_ff};
			else if (i_avs_address == `BPS_REG_LLEN)
				rdata_ff <= {5'h0, lblk_ff, 7'h0};
			else if (i_avs_address == `BPS_REG_STAT)
				rdata_ff <= {28'h0, err_pend_ff, fopt_sync_ff[1], lopt_sync_ff[1], o_data};
			else
				rdata_ff <= 32'h0;
		end
	end
	assign o_avs_readdata = rdata_ff;

	// ****************************************
	// Pattern sequencing
	// ****************************************
	logic [7:0] sidx_ff;
	logic [25:0] laddr_ff;
	logic [17:0] fbyte_ff;
	logic [2:0] fbit_ff;
	logic [6:0] psync_ff;
	logic prbs_bit;
	logic prbs_en;
	logic in_payload;
	logic [7:0] hdr_byte;
	bps_pkg::bps_prbs_t prbs_sel;
	logic pat_bit;
	logic tx_sync;
	logic data_ff;
	logic sync_ff;
	logic err_ff;
	logic long_ff;
	logic [25:0] lend;

	assign lend = 26'({6'h0, lblk_ff} << `BPS_LBLK_SHIFT) - 26'h1;
	assign in_payload = fbyte_ff >= 18'(2 * `BPS_HDR_BYTES);
	assign hdr_byte = (fbyte_ff < `BPS_HDR_BYTES) ? `BPS_A1_BYTE : `BPS_A2_BYTE;
	// Length setting of the random source belongs to whichever mode owns it
	assign prbs_sel = (type_ff == bps_pkg::PAT_FRAME) ?
		bps_pkg::bps_prbs_t'(pay_ff + 3'h1) : prbs_len_ff;
	assign prbs_en = (type_ff == bps_pkg::PAT_PRBS) ||
		(type_ff == bps_pkg::PAT_FRAME && in_payload);

	bps_prbs u_prbs (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_en(prbs_en),
		.i_sel(prbs_sel),
		.o_bit(prbs_bit)
	);

	// Short pattern pointer wraps after the last programmed bit
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			sidx_ff <= 8'h00;
		else if (restart_ff || type_ff != bps_pkg::PAT_SHORT || {1'b0, sidx_ff} >= slen_ff - 9'h1)
			sidx_ff <= 8'h00;
		else
			sidx_ff <= sidx_ff + 8'h01;
	end

	// Long memory address; its bit returns one cycle later
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			laddr_ff <= 26'h0;
		else if (restart_ff || type_ff != bps_pkg::PAT_LONG || laddr_ff >= lend)
			laddr_ff <= 26'h0;
		else
			laddr_ff <= laddr_ff + 26'h1;
	end
	assign o_long_addr = laddr_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fbyte_ff <= 18'h0;
			fbit_ff <= 3'h0;
		end else if (restart_ff || type_ff != bps_pkg::PAT_FRAME) begin
			fbyte_ff <= 18'h0;
			fbit_ff <= 3'h0;
		end else begin
			fbit_ff <= fbit_ff + 3'h1;
			if (fbit_ff == 3'h7)
				fbyte_ff <= (32'(fbyte_ff) == FRAME_BYTES - 1) ? 18'h0 : fbyte_ff + 18'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			psync_ff <= 7'h00;
		else if (restart_ff || type_ff != bps_pkg::PAT_PRBS)
			psync_ff <= 7'h00;
		else
			psync_ff <= psync_ff + 7'h01;
	end

	// Long pattern register stage lines up with the memory latency
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			long_ff <= 1'b0;
		else
			long_ff <= (type_ff == bps_pkg::PAT_LONG) && laddr_ff == 26'h0;
	end

	always_comb begin
		case (type_ff)
			bps_pkg::PAT_PRBS: begin
				pat_bit = prbs_bit;
				tx_sync = psync_ff == 7'h00;
			end
			bps_pkg::PAT_SHORT: begin
				pat_bit = smem_ff[sidx_ff];
				tx_sync = sidx_ff == 8'h00;
			end
			bps_pkg::PAT_LONG: begin
				pat_bit = i_long_bit;
				tx_sync = long_ff;
			end
			default: begin
				pat_bit = in_payload ? prbs_bit : hdr_byte[3'h7 - fbit_ff];
				tx_sync = fbyte_ff == 18'h0 && fbit_ff == 3'h0;
			end
		endcase
	end

	assign err_take = err_pend_ff;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			data_ff <= 1'b0;
			sync_ff <= 1'b0;
			err_ff <= 1'b0;
		end else begin
			data_ff <= pat_bit ^ err_take ^ neg_ff;
			sync_ff <= tx_sync;
			err_ff <= err_take;
		end
	end
	assign o_data = data_ff;
	assign o_data_n = ~data_ff;

	bps_trigger u_trig (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_sel(trig_sel_ff),
		.i_tx_sync(sync_ff),
		.i_tx_err(err_ff),
		.i_rx_bit_en(i_rx_bit_en),
		.i_rx_sync(i_rx_sync),
		.i_rx_err(i_rx_err),
		.o_trig(o_trig)
	);

	// ****************************************
	// Checks
	// ****************************************
	logic [7:0] gap_ff;
	logic rst_d_ff;
	logic prbs_d_ff;

	// Zero means no reference yet: a fresh sequence's first sync shows two cycles after restart
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_ff <= 8'h00;
			rst_d_ff <= 1'b0;
			prbs_d_ff <= 1'b0;
		end else begin
			rst_d_ff <= restart_ff;
			prbs_d_ff <= type_ff == bps_pkg::PAT_PRBS;
			if (restart_ff || rst_d_ff || !prbs_d_ff || type_ff != bps_pkg::PAT_PRBS)
				gap_ff <= 8'h00;
			else if (sync_ff)
				gap_ff <= 8'h01;
			else if (gap_ff != 8'h00)
				gap_ff <= gap_ff + 8'h01;
		end
	end

	chk_sync_period: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(sync_ff && type_ff == bps_pkg::PAT_PRBS && gap_ff != 8'h00) |->
		gap_ff == `BPS_SYNC_PERIOD)
		else $error("random sync spacing is not 128 bits");
	chk_long_option: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(type_ff == bps_pkg::PAT_LONG) |-> $past(lopt_sync_ff[1]))
		else $error("long type active without option");
	chk_frame_option: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(type_ff == bps_pkg::PAT_FRAME) |-> $past(fopt_sync_ff[1]))
		else $error("frame type active without option");
	chk_short_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!restart_ff |-> {1'b0, sidx_ff} < slen_ff && slen_ff >= `BPS_SLEN_MIN &&
		slen_ff <= `BPS_SLEN_MAX)
		else $error("short pattern index or length out of range");
	chk_err_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		err_pend_ff && !(wr_en && i_avs_writedata[`BPS_CTRL_ERR_BIT]) |=> err_ff && !err_pend_ff)
		else $error("inserted error not flagged");
	chk_polarity: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!err_take && !restart_ff) |=> o_data == ($past(pat_bit) ^ $past(neg_ff)))
		else $error("output polarity wrong");
	chk_bus_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("bus access did not finish in one wait state");
	chk_frame_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		32'(fbyte_ff) < FRAME_BYTES) else $error("frame byte count overran");
endmodule

// file: inc/bps_defines.svh
// Register map, field positions and counts of the pattern source
`ifndef BPS_DEFINES_SVH
`define BPS_DEFINES_SVH
`define BPS_ADDR_W 5
`define BPS_REG_CTRL 5'h00
`define BPS_REG_TRIG 5'h04
`define BPS_REG_SLEN 5'h08
`define BPS_REG_LLEN 5'h0c
`define BPS_REG_SBYTE 5'h10
`define BPS_REG_SBIT 5'h14
`define BPS_REG_STAT 5'h18
`define BPS_CTRL_TYPE_LSB 0
`define BPS_CTRL_PRBS_LSB 2
`define BPS_CTRL_PAY_LSB 5
`define BPS_CTRL_NEG_BIT 8
`define BPS_CTRL_ERR_BIT 9
`define BPS_CTRL_RST 10'h000
`define BPS_SLEN_MIN 9'h010
`define BPS_SLEN_MAX 9'h100
`define BPS_LBLK_MIN 20'h00002
`define BPS_LBLK_SHIFT 7
`define BPS_SYNC_PERIOD 8'h80
`define BPS_PRBS_CODES 3'h7
`define BPS_PAY_CODES 3'h6
`define BPS_FRAME_BYTES 155520
`define BPS_LONG_BLOCKS 524288
`define BPS_HDR_BYTES 18'h000c0
`define BPS_A1_BYTE 8'hf6
`define BPS_A2_BYTE 8'h28
`endif

// file: inc/bps_pkg.sv
// Types shared by the pattern source modules
package bps_pkg;
	typedef enum logic [1:0] {PAT_PRBS, PAT_SHORT, PAT_LONG, PAT_FRAME} bps_pat_t;
	typedef enum logic [2:0] {PRBS_7, PRBS_9, PRBS_10, PRBS_11, PRBS_15, PRBS_23,
		PRBS_31} bps_prbs_t;
	typedef enum logic [2:0] {TRG_TX16, TRG_TX64, TRG_TXSYNC, TRG_TXERR, TRG_RX16,
		TRG_RX64, TRG_RXSYNC, TRG_RXERR} bps_trig_t;
endpackage

// file: rtl/bps_prbs.sv
// Selectable-length maximal LFSR, one bit per enabled cycle
`timescale 1ns/100ps
module bps_prbs (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire bps_pkg::bps_prbs_t i_sel,
	output logic o_bit
);
	logic [30:0] state_ff;
	bps_pkg::bps_prbs_t sel_ff;
	logic fb;

	// Feedback taps of the usual polynomials x^n + x^t + 1
	function automatic logic feedback(input logic [30:0] s, input bps_pkg::bps_prbs_t sel);
		case (sel)
			bps_pkg::PRBS_7: feedback = s[6] ^ s[5];
			bps_pkg::PRBS_9: feedback = s[8] ^ s[4];
			bps_pkg::PRBS_10: feedback = s[9] ^ s[6];
			bps_pkg::PRBS_11: feedback = s[10] ^ s[8];
			bps_pkg::PRBS_15: feedback = s[14] ^ s[13];
			bps_pkg::PRBS_23: feedback = s[22] ^ s[17];
			default: feedback = s[30] ^ s[27];
		endcase
	endfunction

	assign fb = feedback(state_ff, i_sel);
	assign o_bit = fb;

	// A length change reseeds with all ones so the register never locks at zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= 31'h7fffffff;
			sel_ff <= bps_pkg::PRBS_7;
		end else if (sel_ff != i_sel) begin
			state_ff <= 31'h7fffffff;
			sel_ff <= i_sel;
		end else if (i_en) begin
			state_ff <= {state_ff[29:0], fb};
		end
	end

	// Longer sequences hold runs of up to 30 zeros, so only the whole register may be tested
	chk_prbs_alive: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_ff != 31'h0) else $error("lfsr state collapsed to zero");
endmodule

// file: rtl/bps_trigger.sv
// Trigger output selector for transmit and receive events
`timescale 1ns/100ps
module bps_trigger (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire bps_pkg::bps_trig_t i_sel,
	input wire logic i_tx_sync,
	input wire logic i_tx_err,
	input wire logic i_rx_bit_en,
	input wire logic i_rx_sync,
	input wire logic i_rx_err,
	output logic o_trig
);
	logic [5:0] tx_cnt_ff;
	logic [5:0] rx_cnt_ff;
	logic trig_ff;
	logic nxt_trig;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			tx_cnt_ff <= 6'h00;
		else
			tx_cnt_ff <= tx_cnt_ff + 6'h01;
	end

	// Receive divider counts checker clock enables, so it follows the recovered rate
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			rx_cnt_ff <= 6'h00;
		else if (i_rx_bit_en)
			rx_cnt_ff <= rx_cnt_ff + 6'h01;
	end

	always_comb begin
		case (i_sel)
			bps_pkg::TRG_TX16: nxt_trig = tx_cnt_ff[3];
			bps_pkg::TRG_TX64: nxt_trig = tx_cnt_ff[5];
			bps_pkg::TRG_TXSYNC: nxt_trig = i_tx_sync;
			bps_pkg::TRG_TXERR: nxt_trig = i_tx_err;
			bps_pkg::TRG_RX16: nxt_trig = rx_cnt_ff[3];
			bps_pkg::TRG_RX64: nxt_trig = rx_cnt_ff[5];
			bps_pkg::TRG_RXSYNC: nxt_trig = i_rx_sync;
			default: nxt_trig = i_rx_err;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			trig_ff <= 1'b0;
		else
			trig_ff <= nxt_trig;
	end
	assign o_trig = trig_ff;

	chk_trig_rx_err: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_sel == bps_pkg::TRG_RXERR && i_rx_err) |=> o_trig)
		else $error("receive error not passed to trigger");
	// Three cycles of the same choice make sure the rise is the divider's own
	chk_trig_tx16: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_sel == bps_pkg::TRG_TX16)[*3] ##0 $rose(o_trig) |=>
		(o_trig || i_sel != bps_pkg::TRG_TX16)[*7] ##1
		(!o_trig || i_sel != bps_pkg::TRG_TX16))
		else $error("divide by 16 trigger period wrong");
endmodule

// file: dv/bps_far_model.sv
// Far-side model: long pattern memory and checker event source
`timescale 1ns/100ps
module bps_far_model (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [25:0] i_long_addr,
	input wire logic i_kick_sync,
	input wire logic i_kick_err,
	output logic o_long_bit,
	output logic o_rx_bit_en,
	output logic o_rx_sync,
	output logic o_rx_err
);
	// Memory answers one cycle after the address; checker clock runs at half rate
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_long_bit <= 1'b0;
			o_rx_bit_en <= 1'b0;
			o_rx_sync <= 1'b0;
			o_rx_err <= 1'b0;
		end else begin
			o_long_bit <= ^i_long_addr[3:0];
			o_rx_bit_en <= ~o_rx_bit_en;
			o_rx_sync <= i_kick_sync;
			o_rx_err <= i_kick_err;
		end
	end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the pattern source
`timescale 1ns/100ps
`include "bps_defines.svh"
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [`BPS_ADDR_W-1:0] addr = '0;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = '0;
	logic long_opt = 1'b0;
	logic frame_opt = 1'b0;
	logic kick_sync = 1'b0;
	logic kick_err = 1'b0;
	logic [31:0] rdata, e, m;
	logic waitreq, long_bit, rx_en, rx_sync, rx_err, dout, dout_n, trig, tprev;
	logic [25:0] long_addr;
	logic [31:0] exp_q[$], msk_q[$];
	logic pat[256];
	logic cap[512];
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	int rises = 0;
	int rise_at = 0;
	int gap = 0;
	int ta[7] = '{7, 9, 10, 11, 15, 23, 31};
	int tb[7] = '{6, 5, 7, 9, 14, 18, 28};
	int sel[5] = '{0, 1, 2, 4, 5};
	int per[5] = '{16, 64, 128, 32, 128};
	int r0, len, ok, mt, mx, pol;
	logic [7:0] b;

	bps_pattern_source #(.FRAME_BYTES(400), .LONG_BLOCKS(8)) DUT (.i_clk(clk), .i_rst_n(rst_n),
		.i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_long_option(long_opt),
		.i_frame_option(frame_opt), .o_long_addr(long_addr), .i_long_bit(long_bit),
		.i_rx_bit_en(rx_en), .i_rx_sync(rx_sync), .i_rx_err(rx_err), .o_data(dout),
		.o_data_n(dout_n), .o_trig(trig));
	bps_far_model far (.i_clk(clk), .i_rst_n(rst_n), .i_long_addr(long_addr),
		.i_kick_sync(kick_sync), .i_kick_err(kick_err), .o_long_bit(long_bit),
		.o_rx_bit_en(rx_en), .o_rx_sync(rx_sync), .o_rx_err(rx_err));

	always #2.5 clk = ~clk;

	task automatic cmp(input string what, input logic [31:0] ex, input logic [31:0] seen);
		checks_done++;
		if (seen !== ex) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, ex, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Request is held until the rising edge at which waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd_en <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0);
		cmp("bus wait states", 1, n - 1);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] ex, input logic [31:0] mk);
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		bus(1'b0, a, 32'h0);
	endtask

	task automatic run(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// Read results and trigger edges are sampled mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (rd_en === 1'b1 && waitreq === 1'b0) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			cmp("readdata", e & m, rdata & m);
		end
		if (trig === 1'b1 && tprev !== 1'b1) begin
			gap = cyc - rise_at;
			rise_at = cyc;
			rises++;
		end
		tprev = trig;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			summarize();
		end
	end

	initial begin
		void'($urandom(45431));
		repeat (15) @(posedge clk);
		@(negedge clk);
		cmp("o_data_n in reset", 1, dout_n);
		cmp("o_trig in reset", 0, trig);
		cmp("o_long_addr in reset", 0, long_addr);
		@(posedge clk);
		rst_n <= 1'b1;
		rd(`BPS_REG_CTRL, 0, 32'h3ff);
		rd(5'h1c, 0, 32'hffffffff);
		rd(`BPS_REG_STAT, 0, 32'h6);
		done("reset");
		for (int c = 0; c < 7; c++) begin
			pol = c % 2;
			wr(`BPS_REG_CTRL, (32'(pol) << 8) | (32'(c) << 2));
			run(6);
			for (int i = 0; i < 90; i++) begin
				@(negedge clk);
				cap[i] = dout;
				cmp("o_data_n", {31'h0, ~dout}, dout_n);
			end
			for (int i = 31; i < 90; i++)
				cmp("prbs bit", cap[i - ta[c]] ^ cap[i - tb[c]] ^ pol, cap[i]);
		end
		wr(`BPS_REG_CTRL, 32'h1c);
		rd(`BPS_REG_CTRL, 32'h18, 32'h1c);
		wr(`BPS_REG_CTRL, 32'h2);
		rd(`BPS_REG_CTRL, 0, 32'h3);
		wr(`BPS_REG_CTRL, 32'h3);
		rd(`BPS_REG_CTRL, 0, 32'h3);
		done("prbs");
		wr(`BPS_REG_CTRL, 0);
		for (int t = 0; t < 5; t++) begin
			wr(`BPS_REG_TRIG, sel[t]);
			run(300);
			cmp("trigger period", per[t], gap);
		end
		wr(`BPS_REG_TRIG, 3);
		run(2);
		r0 = rises;
		wr(`BPS_REG_CTRL, 32'h200);
		run(10);
		cmp("tx error pulses", r0 + 1, rises);
		for (int t = 6; t < 8; t++) begin
			wr(`BPS_REG_TRIG, t);
			r0 = rises;
			@(posedge clk);
			kick_sync <= (t == 6);
			kick_err <= (t == 7);
			@(posedge clk);
			kick_sync <= 1'b0;
			kick_err <= 1'b0;
			run(8);
			cmp("rx event pulses", r0 + 1, rises);
		end
		done("trigger");
		wr(`BPS_REG_SLEN, 5);
		rd(`BPS_REG_SLEN, 16, 32'h1ff);
		wr(`BPS_REG_SLEN, 300);
		rd(`BPS_REG_SLEN, 256, 32'h1ff);
		len = 16 + $urandom % 41;
		wr(`BPS_REG_SLEN, len);
		for (int k = 0; k < 7; k++) begin
			b = 8'($urandom);
			wr(`BPS_REG_SBYTE, (k << 8) | b);
			for (int j = 0; j < 8; j++) pat[8 * k + j] = b[7 - j];
		end
		pat[5] = 1'($urandom);
		wr(`BPS_REG_SBIT, (5 << 8) | pat[5]);
		wr(`BPS_REG_TRIG, 2);
		wr(`BPS_REG_CTRL, 32'h1d);
		run(3 * len + 10);
		cmp("short sync period", len, gap);
		for (int i = 0; i < 2 * len; i++) begin
			@(negedge clk);
			cap[i] = dout;
		end
		ok = 0;
		for (int r = 0; r < len; r++) begin
			mt = 1;
			for (int i = 0; i < 2 * len; i++) if (cap[i] !== pat[(i + r) % len]) mt = 0;
			if (mt == 1) ok = 1;
		end
		cmp("short stream", 1, ok);
		done("short");
		long_opt <= 1'b1;
		run(4);
		wr(`BPS_REG_LLEN, 32'h80);
		rd(`BPS_REG_LLEN, 32'h100, 32'hffffffff);
		wr(`BPS_REG_LLEN, 32'h64 << 7);
		rd(`BPS_REG_LLEN, 32'h400, 32'hffffffff);
		wr(`BPS_REG_LLEN, 32'h100);
		wr(`BPS_REG_CTRL, 32'h2);
		rd(`BPS_REG_CTRL, 32'h2, 32'h3);
		run(600);
		cmp("long sync period", 256, gap);
		mx = 0;
		repeat (300) begin
			@(negedge clk);
			if (int'(long_addr) > mx) mx = int'(long_addr);
			cmp("long stream", {31'h0, ^(4'(long_addr) - 4'h2)}, dout);
		end
		cmp("long address top", 255, mx);
		long_opt <= 1'b0;
		run(4);
		rd(`BPS_REG_CTRL, 0, 32'h3);
		done("long");
		frame_opt <= 1'b1;
		run(4);
		wr(`BPS_REG_CTRL, 32'h3 | (5 << 5));
		rd(`BPS_REG_CTRL, 32'ha3, 32'he3);
		wr(`BPS_REG_CTRL, 32'h3 | (6 << 5));
		rd(`BPS_REG_CTRL, 32'ha0, 32'he0);
		run(7000);
		cmp("frame sync period", 3200, gap);
		done("frame");
		summarize();
	end
endmodule
